// [design/csp_defs.vh]
// constants for the card socket power and interrupt control block
`ifndef CSP_DEFS_VH
`define CSP_DEFS_VH

// ********************************************
// register offsets (byte addresses, 12 bits)
// ********************************************
`define CSP_OFS_PWR_A     12'h002
`define CSP_OFS_IGC_A     12'h003
`define CSP_OFS_PWR_B     12'h042
`define CSP_OFS_IGC_B     12'h043
`define CSP_OFS_CB_PWR    12'h802
`define CSP_OFS_CB_IGC    12'h803

// ********************************************
// reset values
// ********************************************
`define CSP_PWR_RST       8'h00
`define CSP_IGC_RST       8'h00

// ********************************************
// power register fields
// ********************************************
`define CSP_PWR_GATE      7
`define CSP_PWR_AUTO      5
`define CSP_PWR_SUP_ON    4
`define CSP_PWR_VCC_HI    4
`define CSP_PWR_VCC_LO    3
`define CSP_PWR_VPP_HI    1
`define CSP_PWR_VPP_LO    0
// writable and readable bits of each layout
`define CSP_PWR_MASK_ORIG 8'hb3
`define CSP_PWR_MASK_LATE 8'h9b

// ********************************************
// interrupt and general control fields
// ********************************************
`define CSP_IGC_RING      7
`define CSP_IGC_RESET     6
`define CSP_IGC_KIND      5
`define CSP_IGC_CSC_PCI   4
`define CSP_IGC_PICK_HI   3
`define CSP_IGC_PICK_LO   0

// ********************************************
// encodings
// ********************************************
`define CSP_COMPAT_ORIG   4'h2
`define CSP_VPP_NONE      2'h0
`define CSP_VPP_VCC       2'h1
`define CSP_VPP_12V       2'h2
`define CSP_VCC_5V        2'h2
`define CSP_VCC_3V3       2'h3
`define CSP_PICK_NONE     4'h0
`define CSP_PICK_SMI      4'h2

`endif

// [design/csp_irq_steer.v]
// steers one interrupt event onto the line chosen by a 4-bit pick code
`include "csp_defs.vh"

module csp_irq_steer
(
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // event and selection
   input  wire        evt,
   input  wire        en,
   input  wire [3:0]  pick,
   // steered outputs
   output reg  [15:0] irq_q,
   output reg         smi_q
);

   // ********************************************
   // one flop per line
   // ********************************************
   genvar k;
   generate
      for (k = 0; k < 16; k = k + 1)
      begin : g_line
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               irq_q[k] <= 1'b0;
            else
               // code 0 routes nothing and code 2 is the smi, not a line
               irq_q[k] <= en & evt & (pick == k) & (k != 0) & (k != 2);
         end
      end
   endgenerate

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         smi_q <= 1'b0;
      else
         smi_q <= en & evt & (pick == `CSP_PICK_SMI);
   end

endmodule // csp_irq_steer

// [design/csp_ctrl.v]
// two-socket power, reset and interrupt steering registers
`include "csp_defs.vh"

module csp_ctrl
(
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // register port
   input  wire [11:0] reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   input  wire        cb_sock,
   output wire [7:0]  reg_rdata,
   output wire        reg_rvalid,
   // system side state
   input  wire [3:0]  compat_revision_field,
   input  wire [1:0]  system_supply_bit,
   input  wire [7:0]  status_change_irq_pick,
   // card side inputs, socket b in the upper bits
   input  wire [3:0]  card_detect_n,
   input  wire [1:0]  battery1_or_ring_pin,
   input  wire [1:0]  card_func_irq,
   input  wire [1:0]  status_change_evt,
   // card and switch outputs
   output wire [1:0]  card_output_gate,
   output wire [1:0]  vcc_5v_on,
   output wire [1:0]  vcc_3v3_on,
   output wire [1:0]  vpp_vcc_on,
   output wire [1:0]  vpp_12v_on,
   output wire [1:0]  socket_power_state,
   output wire [1:0]  card_reset,
   output wire [1:0]  card_kind,
   output wire [1:0]  ring_indicate,
   output wire [1:0]  battery1_level,
   // interrupt outputs
   output wire [1:0]  status_change_to_pci,
   output wire [31:0] card_irq_lines,
   output wire [1:0]  card_smi,
   output wire [31:0] csc_irq_lines,
   output wire [1:0]  csc_smi
);

   // ********************************************
   // address decode
   // ********************************************
   // returns {hit, socket, is_ctrl}
   function [2:0] dec;
      input [11:0] a;
      input        sock;
      begin
         case (a)
            `CSP_OFS_PWR_A:  dec = 3'h4;
            `CSP_OFS_IGC_A:  dec = 3'h5;
            `CSP_OFS_PWR_B:  dec = 3'h6;
            `CSP_OFS_IGC_B:  dec = 3'h7;
            `CSP_OFS_CB_PWR: dec = {1'b1, sock, 1'b0};
            `CSP_OFS_CB_IGC: dec = {1'b1, sock, 1'b1};
            default:         dec = 3'h0;
         endcase
      end
   endfunction

   // mask of live power bits for the active layout
   function [7:0] pwr_mask;
      input orig;
      begin
         if (orig)
            pwr_mask = `CSP_PWR_MASK_ORIG;
         else
            pwr_mask = `CSP_PWR_MASK_LATE;
      end
   endfunction

   // returns {3.3 V, 5 V} for a later-layout supply code; 00 and 01 both mean off
   function [1:0] vcc_dec;
      input [1:0] code;
      begin
         case (code)
            `CSP_VCC_5V:  vcc_dec = 2'b01;
            `CSP_VCC_3V3: vcc_dec = 2'b10;
            default:      vcc_dec = 2'b00;
         endcase
      end
   endfunction

   wire [2:0]  wdec = dec(reg_addr, cb_sock);
   wire [2:0]  rdec = dec(reg_addr, cb_sock);
   // the revision field lives elsewhere; only its value is watched here
   wire        orig_mode = (compat_revision_field == `CSP_COMPAT_ORIG);
   wire [7:0]  live_mask = pwr_mask(orig_mode);

   wire [15:0] pwr_all;
   wire [15:0] igc_all;

   // ********************************************
   // per-socket logic
   // ********************************************
   genvar s;
   generate
      for (s = 0; s < 2; s = s + 1)
      begin : g_sock
         reg  [7:0] pwr_q;
         reg  [7:0] igc_q;
         reg        gate_q;
         reg        v5_q;
         reg        v33_q;
         reg        pvcc_q;
         reg        p12_q;
         reg        pstate_q;
         reg        crst_q;
         reg        kind_q;
         reg        ring_q;
         reg        bat_q;
         reg        cpci_q;
         wire       wr_pwr;
         wire       wr_igc;
         wire [7:0] pwr_eff;
         wire       present;
         wire [1:0] vcc_code;
         wire [1:0] vpp_code;
         wire       sup_orig;
         wire       sup_late;
         wire       sup_on;
         wire       vpp_vcc_d;
         wire       vpp_12v_d;
         wire [3:0] pick;
         wire       to_pci;
         wire [1:0] vcc_hit;
         wire [7:0] pwr_d;
         wire [7:0] igc_d;
         wire       gate_d;
         wire       v5_d;
         wire       v33_d;
         wire       pstate_d;
         wire       crst_d;
         wire       kind_d;
         wire       ring_d;
         wire       bat_d;
         wire       cpci_d;

         assign wr_pwr = reg_wr & wdec[2] & (wdec[1] == s) & ~wdec[0];
         assign wr_igc = reg_wr & wdec[2] & (wdec[1] == s) & wdec[0];
         // reserved bits of the active layout are dropped on the way in
         assign pwr_d  = wr_pwr ? (reg_wdata & live_mask) : pwr_q;
         assign igc_d  = wr_igc ? reg_wdata : igc_q;

         // ********************************************
         // registers
         // ********************************************
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pwr_q <= `CSP_PWR_RST;
               igc_q <= `CSP_IGC_RST;
            end
            else
            begin
               pwr_q <= pwr_d;
               igc_q <= igc_d;
            end
         end

         // stale bits left by a layout change are hidden, not trusted
         assign pwr_eff = pwr_q & live_mask;
         assign pwr_all[8*s+7:8*s] = pwr_eff;
         assign igc_all[8*s+7:8*s] = igc_q;

         // ********************************************
         // supply decode
         // ********************************************
         assign present  = ~card_detect_n[2*s] & ~card_detect_n[2*s+1];
         assign vcc_code = pwr_eff[`CSP_PWR_VCC_HI:`CSP_PWR_VCC_LO];
         assign vpp_code = pwr_eff[`CSP_PWR_VPP_HI:`CSP_PWR_VPP_LO];
         // auto switching drops supply while the card is not fully seated
         assign sup_orig = pwr_eff[`CSP_PWR_SUP_ON] & system_supply_bit[s]
                           & (~pwr_eff[`CSP_PWR_AUTO] | present);
         assign vcc_hit  = vcc_dec(vcc_code);
         assign sup_late = |vcc_hit;
         assign sup_on   = orig_mode ? sup_orig : sup_late;
         assign vpp_vcc_d = sup_on & (vpp_code == `CSP_VPP_VCC);
         assign vpp_12v_d = sup_on & (vpp_code == `CSP_VPP_12V);

         // ********************************************
         // status change routing
         // ********************************************
         assign pick   = igc_q[`CSP_IGC_PICK_HI:`CSP_IGC_PICK_LO];
         assign to_pci = igc_q[`CSP_IGC_CSC_PCI] | (pick == `CSP_PICK_NONE);

         // ********************************************
         // next values
         // ********************************************
         assign gate_d   = pwr_eff[`CSP_PWR_GATE];
         // original layout has no voltage field, so it means 5 V
         assign v5_d     = sup_on & (orig_mode | vcc_hit[0]);
         assign v33_d    = sup_on & ~orig_mode & vcc_hit[1];
         assign pstate_d = sup_on;
         assign crst_d   = ~igc_q[`CSP_IGC_RESET];
         assign kind_d   = igc_q[`CSP_IGC_KIND];
         assign ring_d   = igc_q[`CSP_IGC_RING] & battery1_or_ring_pin[s];
         assign bat_d    = ~igc_q[`CSP_IGC_RING] & battery1_or_ring_pin[s];
         assign cpci_d   = to_pci & status_change_evt[s];

         // ********************************************
         // output flops
         // ********************************************
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               gate_q   <= 1'b0;
               v5_q     <= 1'b0;
               v33_q    <= 1'b0;
               pvcc_q   <= 1'b0;
               p12_q    <= 1'b0;
               pstate_q <= 1'b0;
               crst_q   <= 1'b1;
               kind_q   <= 1'b0;
               ring_q   <= 1'b0;
               bat_q    <= 1'b0;
               cpci_q   <= 1'b0;
            end
            else
            begin
               gate_q   <= gate_d;
               v5_q     <= v5_d;
               v33_q    <= v33_d;
               pvcc_q   <= vpp_vcc_d;
               p12_q    <= vpp_12v_d;
               pstate_q <= pstate_d;
               crst_q   <= crst_d;
               kind_q   <= kind_d;
               ring_q   <= ring_d;
               bat_q    <= bat_d;
               cpci_q   <= cpci_d;
            end
         end

         assign card_output_gate[s]     = gate_q;
         assign vcc_5v_on[s]            = v5_q;
         assign vcc_3v3_on[s]           = v33_q;
         assign vpp_vcc_on[s]           = pvcc_q;
         assign vpp_12v_on[s]           = p12_q;
         assign socket_power_state[s]   = pstate_q;
         assign card_reset[s]           = crst_q;
         assign card_kind[s]            = kind_q;
         assign ring_indicate[s]        = ring_q;
         assign battery1_level[s]       = bat_q;
         assign status_change_to_pci[s] = cpci_q;

         // ********************************************
         // interrupt steering
         // ********************************************
         csp_irq_steer u_card_irq
         (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .evt     (card_func_irq[s]),
            .en      (igc_q[`CSP_IGC_KIND]),
            .pick    (pick),
            .irq_q   (card_irq_lines[16*s+15:16*s]),
            .smi_q   (card_smi[s])
         );

         csp_irq_steer u_csc_irq
         (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .evt     (status_change_evt[s]),
            .en      (~to_pci),
            .pick    (status_change_irq_pick[4*s+3:4*s]),
            .irq_q   (csc_irq_lines[16*s+15:16*s]),
            .smi_q   (csc_smi[s])
         );
      end
   endgenerate

   // ********************************************
   // read path
   // ********************************************
   reg  [7:0] rdata_q;
   reg        rvalid_q;
   reg  [7:0] rdata_d;

   always @*
   begin
      rdata_d = 8'h00;
      if (rdec[2])
      begin
         case (rdec[1:0])
            2'h0:    rdata_d = pwr_all[7:0];
            2'h1:    rdata_d = igc_all[7:0];
            2'h2:    rdata_d = pwr_all[15:8];
            2'h3:    rdata_d = igc_all[15:8];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= reg_rd;
         // unmapped reads answer zero, so a stray read never shows old data
         if (reg_rd)
            rdata_q <= rdata_d;
      end
   end

   assign reg_rdata  = rdata_q;
   assign reg_rvalid = rvalid_q;

endmodule // csp_ctrl

// [tb/csp_checker.sv]
// assertions on the socket power and interrupt control ports
module csp_checker (
   // clock and reset
   input wire        sys_clk,
   input wire        rst_n,
   // register port
   input wire [11:0] reg_addr,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_wdata,
   input wire [7:0]  reg_rdata,
   input wire        reg_rvalid,
   input wire [3:0]  compat_revision_field,
   // socket side
   input wire [1:0]  battery1_or_ring_pin,
   input wire [1:0]  status_change_evt,
   input wire [1:0]  card_output_gate,
   input wire [1:0]  vcc_5v_on,
   input wire [1:0]  vcc_3v3_on,
   input wire [1:0]  vpp_vcc_on,
   input wire [1:0]  vpp_12v_on,
   input wire [1:0]  socket_power_state,
   input wire [1:0]  card_reset,
   input wire [1:0]  ring_indicate,
   input wire [1:0]  status_change_to_pci
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_wr_pwr; reg_wr && reg_addr == 12'h002; endsequence
   sequence s_wr_igc; reg_wr && reg_addr == 12'h003; endsequence
   sequence s_rd_pwr; reg_rd && reg_addr == 12'h002; endsequence
   // outputs lag a write by two edges, so $past reaches back two
   property p_gate;
      s_wr_pwr |-> ##2 card_output_gate[0] == $past(reg_wdata[7], 2);
   endproperty
   property p_card_rst;
      s_wr_igc |-> ##2 card_reset[0] == !$past(reg_wdata[6], 2);
   endproperty
   property p_rd_late;
      s_rd_pwr ##0 compat_revision_field != 4'h2 |=> reg_rvalid && (reg_rdata & 8'h64) == 8'h00;
   endproperty
   property p_rd_orig;
      s_rd_pwr ##0 compat_revision_field == 4'h2 |=> reg_rvalid && (reg_rdata & 8'h4c) == 8'h00;
   endproperty
   property p_vpp_gated;
      ((vpp_vcc_on | vpp_12v_on) & ~(vcc_5v_on | vcc_3v3_on)) == 2'b00;
   endproperty
   property p_pwr_state;
      socket_power_state == (vcc_5v_on | vcc_3v3_on);
   endproperty
   property p_ring;
      $rose(ring_indicate[0]) |-> $past(battery1_or_ring_pin[0]);
   endproperty
   property p_csc_pci;
      status_change_to_pci[0] |-> $past(status_change_evt[0]);
   endproperty
   property p_rvalid;
      reg_rd |=> reg_rvalid;
   endproperty
   a_gate: assert property (p_gate) else $error("output gate wrong");
   a_card_rst: assert property (p_card_rst) else $error("card reset wrong");
   a_rd_late: assert property (p_rd_late) else $error("reserved bits set");
   a_rd_orig: assert property (p_rd_orig) else $error("reserved bits set");
   a_vpp_gated: assert property (p_vpp_gated) else $error("vpp without supply");
   a_pwr_state: assert property (p_pwr_state) else $error("power state wrong");
   a_ring: assert property (p_ring) else $error("ring without pin");
   a_csc_pci: assert property (p_csc_pci) else $error("pci irq without event");
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
endmodule // csp_checker

bind csp_ctrl csp_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .compat_revision_field(compat_revision_field),
   .battery1_or_ring_pin(battery1_or_ring_pin), .status_change_evt(status_change_evt),
   .card_output_gate(card_output_gate), .vcc_5v_on(vcc_5v_on), .vcc_3v3_on(vcc_3v3_on),
   .vpp_vcc_on(vpp_vcc_on), .vpp_12v_on(vpp_12v_on), .socket_power_state(socket_power_state),
   .card_reset(card_reset), .ring_indicate(ring_indicate),
   .status_change_to_pci(status_change_to_pci));

// [tb/csp_card_model.sv]
// behavioural card pins for both sockets
module csp_card_model (
   // scenario commands
   input  wire [1:0] present,
   input  wire [1:0] want_irq,
   input  wire [1:0] want_csc,
   input  wire [1:0] ring_low,
   // socket pins
   input  wire [1:0] card_reset,
   output wire [3:0] card_detect_n,
   output wire [1:0] battery1_or_ring_pin,
   output wire [1:0] card_func_irq,
   output wire [1:0] status_change_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   // empty socket: detects and battery pin float to their pull-ups
   assign card_detect_n = ~{present[1], present[1], present[0], present[0]};
   assign battery1_or_ring_pin = ~(present & ring_low);
   // a card held in reset raises no interrupt
   assign card_func_irq = present & want_irq & ~card_reset;
   assign status_change_evt = want_csc;
endmodule // csp_card_model

// [tb/tb.sv]
// self-checking bench for the socket control registers
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        cb_sock = 1'b0;
   logic [3:0]  compat_revision_field = 4'h0;
   logic [1:0]  system_supply_bit = 2'h0;
   logic [7:0]  status_change_irq_pick = 8'h00;
   logic [1:0]  present = 2'h0, want_irq = 2'h0, want_csc = 2'h0, ring_low = 2'h0;
   wire  [7:0]  reg_rdata;
   wire         reg_rvalid;
   wire  [3:0]  card_detect_n;
   wire  [1:0]  battery1_or_ring_pin, card_func_irq, status_change_evt, card_output_gate;
   wire  [1:0]  vcc_5v_on, vcc_3v3_on, vpp_vcc_on, vpp_12v_on, socket_power_state;
   wire  [1:0]  card_reset, card_kind, ring_indicate, battery1_level;
   wire  [1:0]  status_change_to_pci, card_smi, csc_smi;
   wire  [31:0] card_irq_lines, csc_irq_lines;
   int          err_count = 0, n_compared = 0, cyc = 0;

   always #5 sys_clk = ~sys_clk;

   csp_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .cb_sock(cb_sock), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .compat_revision_field(compat_revision_field),
      .system_supply_bit(system_supply_bit), .status_change_irq_pick(status_change_irq_pick),
      .card_detect_n(card_detect_n), .battery1_or_ring_pin(battery1_or_ring_pin),
      .card_func_irq(card_func_irq), .status_change_evt(status_change_evt),
      .card_output_gate(card_output_gate), .vcc_5v_on(vcc_5v_on), .vcc_3v3_on(vcc_3v3_on),
      .vpp_vcc_on(vpp_vcc_on), .vpp_12v_on(vpp_12v_on), .socket_power_state(socket_power_state),
      .card_reset(card_reset), .card_kind(card_kind), .ring_indicate(ring_indicate),
      .battery1_level(battery1_level), .status_change_to_pci(status_change_to_pci),
      .card_irq_lines(card_irq_lines), .card_smi(card_smi), .csc_irq_lines(csc_irq_lines),
      .csc_smi(csc_smi));
   csp_card_model card (.present(present), .want_irq(want_irq), .want_csc(want_csc),
      .ring_low(ring_low), .card_reset(card_reset), .card_detect_n(card_detect_n),
      .battery1_or_ring_pin(battery1_or_ring_pin), .card_func_irq(card_func_irq),
      .status_change_evt(status_change_evt));

   // ****************************************
   // register access and settling
   // ****************************************
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      // reg_rvalid stands for one cycle only, right after the edge that took the read; reg_rdata holds until the next read
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
      reg_rd = 1'b0;
   endtask
   // three edges cover register, output and the card's own response
   task automatic st;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_late;
      wr(12'h002, 8'hff);
      rd(12'h002, 8'h9b);
      rd(12'h802, 8'h9b);
      for (int i = 0; i < 4; i++)
      begin
         for (int j = 0; j < 4; j++)
         begin
            wr(12'h002, 8'(8'h80 | (i << 3) | j));
            st();
            `CHK(vcc_5v_on[0], i == 2)
            `CHK(vcc_3v3_on[0], i == 3)
            `CHK(vpp_vcc_on[0], i > 1 && j == 1)
            `CHK(vpp_12v_on[0], i > 1 && j == 2)
            `CHK(socket_power_state[0], i > 1)
            `CHK(card_output_gate, 2'b01)
         end
      end
   endtask
   task automatic t_orig;
      compat_revision_field = 4'h2;
      wr(12'h002, 8'hff);
      rd(12'h002, 8'hb3);
      compat_revision_field = 4'h0;
      rd(12'h002, 8'h93);
      compat_revision_field = 4'h2;
      system_supply_bit = 2'b01;
      wr(12'h002, 8'hb2);
      st();
      `CHK(vcc_5v_on[0], 1'b0)
      present = 2'b01;
      st();
      `CHK(vcc_5v_on[0], 1'b1)
      `CHK(vpp_12v_on[0], 1'b1)
      system_supply_bit = 2'b00;
      st();
      `CHK(vcc_5v_on[0], 1'b0)
      system_supply_bit = 2'b01;
      wr(12'h002, 8'h80);
      st();
      `CHK(socket_power_state[0], 1'b0)
   endtask
   task automatic t_igc;
      `CHK(card_reset, 2'b11)
      wr(12'h003, 8'he0);
      st();
      rd(12'h003, 8'he0);
      `CHK(card_reset, 2'b10)
      `CHK(card_kind, 2'b01)
      `CHK(ring_indicate, 2'b01)
      ring_low = 2'b01;
      st();
      `CHK(ring_indicate, 2'b00)
      ring_low = 2'b00;
      wr(12'h003, 8'h60);
      st();
      `CHK(battery1_level[0], 1'b1)
      want_irq = 2'b01;
      for (int k = 0; k < 16; k++)
      begin
         wr(12'h003, 8'(8'h60 | k));
         st();
         `CHK(card_irq_lines, (k == 0 || k == 2) ? 32'h0 : 32'h1 << k)
         `CHK(card_smi[0], k == 2)
      end
      want_csc = 2'b01;
      status_change_irq_pick = 8'h05;
      wr(12'h003, 8'h61);
      st();
      `CHK(status_change_to_pci[0], 1'b0)
      `CHK(csc_irq_lines, 32'h20)
      status_change_irq_pick = 8'h02;
      st();
      `CHK(csc_smi, 2'b01)
      `CHK(csc_irq_lines, 32'h0)
      wr(12'h003, 8'h71);
      st();
      `CHK(status_change_to_pci[0], 1'b1)
      wr(12'h003, 8'h60);
      st();
      `CHK(status_change_to_pci[0], 1'b1)
   endtask
   task automatic t_sock_b;
      cb_sock = 1'b1;
      wr(12'h803, 8'h40);
      st();
      `CHK(card_reset, 2'b00)
      rd(12'h043, 8'h40);
      rd(12'h003, 8'h60);
      rd(12'h010, 8'h00);
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         stop_test();
      end
   end

   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      `CHK(card_output_gate, 2'b00)
      rd(12'h042, 8'h00);
      t_late();
      t_orig();
      t_igc();
      t_sock_b();
      stop_test();
   end
endmodule // tb
